/* dslp_display_serial_load_port.sv */
// serial load port, command fifo and multiplexed display driver
`default_nettype none

// command word fifo, flop storage
module dslp_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
) (
  input wire logic sys_clk,              // system clock
  input wire logic reset_n,              // async reset, active low
  input wire logic in_valid,             // word offered
  output logic in_ready,                 // room for a word
  input wire logic [WIDTH-1:0] in_data,  // word in
  output logic out_valid,                // word available
  input wire logic out_ready,            // consumer takes word
  output logic [WIDTH-1:0] out_data      // oldest word
);
  localparam int AW = $clog2(DEPTH);
  logic [DEPTH-1:0][WIDTH-1:0] mem_q;
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;
  // handshake terms
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign in_ready = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data = mem_q[rd_q];
  // storage write
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      mem_q <= '0;
      wr_q <= '0;
    end else if (push) begin
      mem_q[wr_q] <= in_data;
      wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
    end
  end
  // read pointer and fill count
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// Operation
// - sample input on serial clock rise, shift
// - output repeats input 16.5 clocks later
// - serial output changes on falling edges only
// - serial output always driven, never floating
// - select rise latches last sixteen bits
// - select variant shifts only while select low
// - select variant ignores clock while select high
// - digit lines sink, high when digit off
// - display blank after power-up until programmed
// - host sets number of scanned digits
// - per digit hex, BCD or raw segments
// - software reset and optional external scan clock
// - per-segment blink, phase syncable across chips
// - shutdown keeps all stored display settings
module dslp_display_serial_load_port
  import dslp_pkg::*;
#(
  parameter int BLINK_CYC = BLINK_HALF_CYC  // blink half period in cycles
) (
  input wire logic sys_clk,                  // system clock, 10 MHz
  input wire logic reset_n,                  // async reset, active low
  input wire logic ser_clk,                  // serial clock from host
  input wire logic ser_din,                  // serial data in
  input wire logic latch_select_n,           // load / chip select
  input wire logic cs_mode,                  // 1: chip-select variant
  output logic ser_dout,                     // chained serial data out
  output logic ser_dout_oe,                  // serial out enable, always 1
  output logic [SHIFT_W-1:0] cmd_word,       // latched word to decoder
  output logic cmd_valid,                    // latched word available
  input wire logic cmd_ready,                // decoder takes word
  output logic cmd_overflow,                 // word lost, fifo full
  input wire logic mem_wr,                   // write one digit value
  input wire logic [1:0] mem_idx,            // digit written
  input wire logic [7:0] mem_data,           // digit value
  input wire logic [7:0] decode_mode,        // two mode bits per digit
  input wire logic [1:0] scan_limit,         // last scanned digit
  input wire logic shutdown,                 // blank, keep settings
  input wire logic sw_reset,                 // clear settings
  input wire logic ext_clk_sel,              // scan from external clock
  input wire logic ext_scan_clk,             // external scan clock
  input wire logic [31:0] blink_mask,        // segments that blink
  input wire logic blink_sync,               // restart blink phase
  output logic [DIGITS-1:0] digit_sink_lines,  // digit drives, low = on
  output logic [6:0] segment_source_lines,   // segment a..g drives
  output logic point_source_line             // decimal point drive
);
  logic sclk_q, lsel_q, ext_q;
  logic [SHIFT_W-1:0] shift_q;
  logic tail_q, programmed_q, blink_off_q;
  logic [DIGITS-1:0][7:0] mem_q;
  logic [15:0] scan_cnt_q;
  dslp_slot_e slot_q;
  logic [31:0] blink_cnt_q;
  logic sclk_rise, sclk_fall, port_active, latch_rise, fifo_ready, scan_tick;
  logic [1:0] slot_idx, cur_mode;
  logic [7:0] cur_val, cur_segs, cur_blink;

  // hex glyphs, bit 6 = segment a down to bit 0 = segment g
  function automatic logic [6:0] hex_glyph(input logic [3:0] n);
    case (n)
      4'h0: hex_glyph = 7'h7E;
      4'h1: hex_glyph = 7'h30;
      4'h2: hex_glyph = 7'h6D;
      4'h3: hex_glyph = 7'h79;
      4'h4: hex_glyph = 7'h33;
      4'h5: hex_glyph = 7'h5B;
      4'h6: hex_glyph = 7'h5F;
      4'h7: hex_glyph = 7'h70;
      4'h8: hex_glyph = 7'h7F;
      4'h9: hex_glyph = 7'h7B;
      4'hA: hex_glyph = 7'h77;
      4'hB: hex_glyph = 7'h1F;
      4'hC: hex_glyph = 7'h4E;
      4'hD: hex_glyph = 7'h3D;
      4'hE: hex_glyph = 7'h4F;
      default: hex_glyph = 7'h47;
    endcase
  endfunction

  // code-B glyphs: digits, then dash, E, H, L, P, blank
  function automatic logic [6:0] bcd_glyph(input logic [3:0] n);
    case (n)
      4'hA: bcd_glyph = 7'h01;
      4'hB: bcd_glyph = 7'h4F;
      4'hC: bcd_glyph = 7'h37;
      4'hD: bcd_glyph = 7'h0E;
      4'hE: bcd_glyph = 7'h67;
      4'hF: bcd_glyph = 7'h00;
      default: bcd_glyph = hex_glyph(n);
    endcase
  endfunction

  // slot code to digit number
  function automatic logic [1:0] slot_num(input dslp_slot_e s);
    case (s)
      SLOT_0: slot_num = 2'h0;
      SLOT_1: slot_num = 2'h1;
      SLOT_2: slot_num = 2'h2;
      SLOT_3: slot_num = 2'h3;
      default: slot_num = 2'h0;
    endcase
  endfunction

  // edge detection on the pins, sampled on the system clock
  assign sclk_rise = ser_clk && !sclk_q;
  assign sclk_fall = !ser_clk && sclk_q;
  assign latch_rise = latch_select_n && !lsel_q;
  assign port_active = !cs_mode || !latch_select_n;

  // pin history
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      sclk_q <= 1'b0;
      lsel_q <= 1'b1;
      ext_q <= 1'b0;
    end else begin
      sclk_q <= ser_clk;
      lsel_q <= latch_select_n;
      ext_q <= ext_scan_clk;
    end
  end

  // shift register plus one extra stage for the chain delay
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      shift_q <= '0;
      tail_q <= 1'b0;
    end else if (sclk_rise && port_active) begin
      shift_q <= {shift_q[SHIFT_W-2:0], ser_din};
      tail_q <= shift_q[SHIFT_W-1];
    end
  end

  // chained output moves on falling edges only
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ser_dout <= 1'b0;
    end else if (sclk_fall && port_active) begin
      ser_dout <= tail_q;
    end
  end

  // output enable held high from reset onward
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ser_dout_oe <= 1'b1;
    end else begin
      ser_dout_oe <= 1'b1;
    end
  end

  // latched words go to the external decoder through the fifo
  dslp_fifo #(.WIDTH(SHIFT_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .in_valid(latch_rise),
    .in_ready(fifo_ready),
    .in_data(shift_q),
    .out_valid(cmd_valid),
    .out_ready(cmd_ready),
    .out_data(cmd_word)
  );

  // sticky overflow when a latch meets a full fifo
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      cmd_overflow <= 1'b0;
    end else if (latch_rise && !fifo_ready) begin
      cmd_overflow <= 1'b1;
    end else if (sw_reset) begin
      cmd_overflow <= 1'b0;
    end
  end

  // display memory, untouched by shutdown
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      mem_q <= MEM_RESET;
      programmed_q <= 1'b0;
    end else if (sw_reset) begin
      mem_q <= MEM_RESET;
      programmed_q <= 1'b0;
    end else if (mem_wr) begin
      mem_q[mem_idx] <= mem_data;
      programmed_q <= 1'b1;
    end
  end

  // scan tick from internal divider or external clock edge
  assign scan_tick = ext_clk_sel ? (ext_scan_clk && !ext_q) :
                     (scan_cnt_q == 16'(SCAN_SLOT_CYC - 1));

  // slot divider
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      scan_cnt_q <= '0;
    end else if (scan_tick || ext_clk_sel || sw_reset) begin
      scan_cnt_q <= '0;
    end else begin
      scan_cnt_q <= scan_cnt_q + 16'h0001;
    end
  end

  // digit rotation up to the scan limit
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      slot_q <= SLOT_0;
    end else if (sw_reset) begin
      slot_q <= SLOT_0;
    end else if (scan_tick) begin
      if (slot_num(slot_q) >= scan_limit) begin
        slot_q <= SLOT_0;
      end else begin
        case (slot_q)
          SLOT_0: slot_q <= SLOT_1;
          SLOT_1: slot_q <= SLOT_2;
          SLOT_2: slot_q <= SLOT_3;
          default: slot_q <= SLOT_0;
        endcase
      end
    end
  end

  // blink phase, restarted by the sync input on every chained chip
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      blink_cnt_q <= '0;
      blink_off_q <= 1'b0;
    end else if (blink_sync) begin
      blink_cnt_q <= '0;
      blink_off_q <= 1'b0;
    end else if (blink_cnt_q >= 32'(BLINK_CYC - 1)) begin
      blink_cnt_q <= '0;
      blink_off_q <= !blink_off_q;
    end else begin
      blink_cnt_q <= blink_cnt_q + 32'h0000_0001;
    end
  end

  // segment pattern of the current digit
  assign slot_idx = slot_num(slot_q);
  assign cur_val = mem_q[slot_idx];
  assign cur_mode = decode_mode[2*slot_idx +: 2];
  assign cur_blink = blink_mask[8*slot_idx +: 8];
  always_comb begin
    case (cur_mode)
      MODE_BCD: cur_segs = {cur_val[7], bcd_glyph(cur_val[3:0])};
      MODE_HEX: cur_segs = {cur_val[7], hex_glyph(cur_val[3:0])};
      default: cur_segs = cur_val;
    endcase
  end

  // registered drive lines, blank on power-up and in shutdown
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      digit_sink_lines <= DIGITS_OFF;
      segment_source_lines <= SEGS_OFF;
      point_source_line <= 1'b0;
    end else if (!programmed_q || shutdown || sw_reset) begin
      digit_sink_lines <= DIGITS_OFF;
      segment_source_lines <= SEGS_OFF;
      point_source_line <= 1'b0;
    end else begin
      digit_sink_lines <= ~(DIGITS'(1) << slot_idx);
      segment_source_lines <= cur_segs[6:0] & ~(cur_blink[6:0] & {7{blink_off_q}});
      point_source_line <= cur_segs[7] & ~(cur_blink[7] & blink_off_q);
    end
  end

  // checks
  sequence s_rise;
    sclk_rise && port_active;
  endsequence
  sequence s_fall;
    sclk_fall && port_active;
  endsequence

  AST_SHIFT_IN: assert property (@(posedge sys_clk) disable iff (!reset_n)
    s_rise |=> shift_q == {$past(shift_q[SHIFT_W-2:0]), $past(ser_din)})
    else $error("shift register did not take the serial input");
  AST_CHAIN_DELAY: assert property (@(posedge sys_clk) disable iff (!reset_n)
    s_rise ##[1:8] s_fall |=> ser_dout == $past(tail_q))
    else $error("serial output not the delayed stage");
  AST_FALL_ONLY: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !$stable(ser_dout) |-> $past(sclk_fall))
    else $error("serial output moved outside a falling edge");
  AST_ALWAYS_DRIVEN: assert property (@(posedge sys_clk) disable iff (!reset_n)
    ser_dout_oe)
    else $error("serial output released");
  AST_LATCH_PUSH: assert property (@(posedge sys_clk) disable iff (!reset_n)
    latch_rise && !cmd_valid |=> cmd_valid && cmd_word == $past(shift_q))
    else $error("latched word not offered to decoder");
  AST_CS_IGNORE: assert property (@(posedge sys_clk) disable iff (!reset_n)
    cs_mode && latch_select_n |=> $stable(shift_q))
    else $error("shift register moved while deselected");
  AST_BLANK_START: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !programmed_q |=> digit_sink_lines == DIGITS_OFF && segment_source_lines == SEGS_OFF)
    else $error("display lit before programming");
  AST_ONE_DIGIT: assert property (@(posedge sys_clk) disable iff (!reset_n)
    $onehot0(~digit_sink_lines))
    else $error("more than one digit enabled");
  AST_SHUTDOWN_KEEP: assert property (@(posedge sys_clk) disable iff (!reset_n)
    shutdown && !mem_wr && !sw_reset |=> $stable(mem_q))
    else $error("shutdown changed stored settings");
  AST_SCAN_LIMIT: assert property (@(posedge sys_clk) disable iff (!reset_n)
    scan_tick && slot_idx >= scan_limit |=> slot_q == SLOT_0)
    else $error("scan passed the digit limit");
endmodule
`default_nettype wire

/* dslp_pkg.sv */
// shared constants for the display serial load port
`default_nettype none
package dslp_pkg;
  localparam int SHIFT_W = 16;
  localparam int DIGITS = 4;
  localparam int FIFO_DEPTH = 4;
  localparam int CLK_PERIOD_NS = 100;
  // one multiplex slot lasts this long
  localparam int SCAN_SLOT_NS = 1000;
  localparam int SCAN_SLOT_CYC = (SCAN_SLOT_NS / CLK_PERIOD_NS < 1) ? 1 :
                                 SCAN_SLOT_NS / CLK_PERIOD_NS;
  // blink half period
  localparam longint BLINK_HALF_NS = 64'h0000_0000_1DCD_6500;
  localparam int BLINK_HALF_CYC = int'(BLINK_HALF_NS / CLK_PERIOD_NS);
  // per-digit decode mode, two bits each
  localparam logic [1:0] MODE_RAW = 2'h0;
  localparam logic [1:0] MODE_BCD = 2'h1;
  localparam logic [1:0] MODE_HEX = 2'h2;
  // output levels
  localparam logic [3:0] DIGITS_OFF = 4'hF;
  localparam logic [6:0] SEGS_OFF = 7'h00;
  localparam logic [31:0] MEM_RESET = 32'h0000_0000;
  // multiplex slots, gray coded along the rotation
  typedef enum logic [1:0] {
    SLOT_0 = 2'h0,
    SLOT_1 = 2'h1,
    SLOT_2 = 2'h3,
    SLOT_3 = 2'h2
  } dslp_slot_e;
endpackage
`default_nettype wire

/* dslp_host_model.sv */
// host side serial master model driving the load port
`default_nettype none
module dslp_host_model (
  input wire logic sys_clk,       // system clock
  input wire logic ser_dout,      // chained data back from the port
  output logic ser_clk,           // serial clock, still between frames
  output logic ser_din,           // serial data
  output logic latch_select_n,    // load or select, idle high
  output logic [15:0] echo_q      // chained bits seen at each fall
);
  timeunit 1ns;
  timeprecision 1ns;
  logic busy = 1'b0;
  // idle levels
  initial begin
    ser_clk = 1'b0;
    ser_din = 1'b0;
    latch_select_n = 1'b1;
    echo_q = 16'h0000;
  end
  // released data line changes every cycle so a stale bit is never trusted
  always @(negedge sys_clk) begin
    if (!busy) begin
      ser_din <= ~ser_din;
    end
  end
  // one frame of n bits, msb first; select pulled low only when sel is set
  task automatic frame(input int n, input logic [15:0] w, input logic sel);
    busy = 1'b1;
    @(negedge sys_clk);
    if (sel) begin
      latch_select_n = 1'b0;
    end
    for (int i = n - 1; i >= 0; i--) begin
      ser_din = w[i];
      repeat (3) @(negedge sys_clk);
      ser_clk = 1'b1;
      repeat (3) @(negedge sys_clk);
      ser_clk = 1'b0;
      repeat (3) @(negedge sys_clk);
      echo_q = {echo_q[14:0], ser_dout};
    end
    latch_select_n = 1'b1;
    repeat (3) @(negedge sys_clk);
    busy = 1'b0;
  endtask
endmodule
`default_nettype wire

/* dslp_display_serial_load_port_tb.sv */
// self-checking bench for the display serial load port
`default_nettype none
module dslp_display_serial_load_port_tb;
  import dslp_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic ser_clk, ser_din, latch_select_n, ser_dout, ser_dout_oe, cs_mode;
  logic cmd_valid, cmd_ready, cmd_overflow, mem_wr, shutdown, sw_reset;
  logic ext_clk_sel, ext_scan_clk, blink_sync, point_source_line;
  logic [15:0] cmd_word, echo_q;
  logic [1:0] mem_idx, scan_limit;
  logic [7:0] mem_data, decode_mode;
  logic [31:0] blink_mask;
  logic [3:0] digit_sink_lines, seen;
  logic [6:0] segment_source_lines;
  logic [7:0] glyph [4] = '{8'h8A, 8'h81, 8'hF7, 8'h8A};
  int bad_count = 0;
  int compares = 0;
  // clock
  initial begin
    forever #50 sys_clk = ~sys_clk;
  end
  dslp_display_serial_load_port #(.BLINK_CYC(8)) dut (
    .sys_clk(sys_clk), .reset_n(reset_n), .ser_clk(ser_clk), .ser_din(ser_din),
    .latch_select_n(latch_select_n), .cs_mode(cs_mode), .ser_dout(ser_dout),
    .ser_dout_oe(ser_dout_oe), .cmd_word(cmd_word), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_overflow(cmd_overflow), .mem_wr(mem_wr),
    .mem_idx(mem_idx), .mem_data(mem_data), .decode_mode(decode_mode),
    .scan_limit(scan_limit), .shutdown(shutdown), .sw_reset(sw_reset),
    .ext_clk_sel(ext_clk_sel), .ext_scan_clk(ext_scan_clk), .blink_mask(blink_mask),
    .blink_sync(blink_sync), .digit_sink_lines(digit_sink_lines),
    .segment_source_lines(segment_source_lines), .point_source_line(point_source_line)
  );
  dslp_host_model host (
    .sys_clk(sys_clk), .ser_dout(ser_dout), .ser_clk(ser_clk), .ser_din(ser_din),
    .latch_select_n(latch_select_n), .echo_q(echo_q)
  );
  // compare a word
  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask
  // compare digit drives and point plus segments
  task automatic chk_disp(input logic [3:0] dig, input logic [7:0] seg);
    chk_word({4'h0, digit_sink_lines, point_source_line, segment_source_lines},
             {4'h0, dig, seg}, "display");
  endtask
  // take the oldest latched word
  task automatic pop(input logic [15:0] exp);
    chk_word({15'h0, cmd_valid}, 16'h0001, "valid");
    chk_word(cmd_word, exp, "word");
    cmd_ready = 1'b1;
    @(negedge sys_clk);
    cmd_ready = 1'b0;
  endtask
  // write one digit value and let the display settle
  task automatic put(input logic [1:0] idx, input logic [7:0] val);
    mem_idx = idx;
    mem_data = val;
    mem_wr = 1'b1;
    @(negedge sys_clk);
    mem_wr = 1'b0;
    repeat (4) @(negedge sys_clk);
  endtask
  // verdict
  task automatic complete_run();
    $display("compares %0d bad %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // watchdog against a hang
  initial begin
    repeat (20000) @(posedge sys_clk);
    bad_count++;
    $display("BAD %0t watchdog expired", $time);
    complete_run();
  end
  // test sequence
  initial begin
    {cs_mode, cmd_ready, mem_wr, shutdown, sw_reset, ext_clk_sel} = 6'h00;
    {ext_scan_clk, blink_sync, mem_idx, scan_limit} = 6'h00;
    {mem_data, decode_mode, blink_mask} = 48'h0;
    repeat (2) @(negedge sys_clk);
    reset_n = 1'b1;
    @(negedge sys_clk);
    chk_disp(4'hF, 8'h00);
    chk_word({15'h0, ser_dout_oe}, 16'h0001, "oe");
    chk_word({15'h0, cmd_valid}, 16'h0000, "empty");
    $display("test reset done");
    host.frame(16, 16'hA5C3, 1'b1);
    pop(16'hA5C3);
    host.frame(16, 16'h3C96, 1'b1);
    chk_word(echo_q, 16'hA5C3, "chain");
    pop(16'h3C96);
    $display("test load done");
    cs_mode = 1'b1;
    host.frame(16, 16'h1234, 1'b1);
    pop(16'h1234);
    host.frame(16, 16'hFFFF, 1'b0);
    host.frame(8, 16'h00E7, 1'b1);
    pop(16'h34E7);
    $display("test select done");
    for (int i = 0; i < 5; i++) begin
      host.frame(16, 16'(16'hB000 + i), 1'b1);
    end
    chk_word({15'h0, cmd_overflow}, 16'h0001, "overflow");
    for (int i = 0; i < 4; i++) begin
      pop(16'(16'hB000 + i));
    end
    chk_word({15'h0, cmd_valid}, 16'h0000, "drained");
    $display("test fifo done");
    for (int m = 0; m < 4; m++) begin
      decode_mode = {6'h00, 2'(m)};
      put(2'h0, 8'h8A);
      chk_disp(4'hE, glyph[m]);
    end
    shutdown = 1'b1;
    repeat (3) @(negedge sys_clk);
    chk_disp(4'hF, 8'h00);
    shutdown = 1'b0;
    repeat (3) @(negedge sys_clk);
    chk_disp(4'hE, 8'h8A);
    $display("test decode done");
    // point of digit 0 blinks; sync restarts the phase with the point lit
    blink_mask = 32'h0000_0080;
    blink_sync = 1'b1;
    @(negedge sys_clk);
    blink_sync = 1'b0;
    repeat (4) @(negedge sys_clk);
    chk_disp(4'hE, 8'h8A);
    repeat (8) @(negedge sys_clk);
    chk_disp(4'hE, 8'h0A);
    repeat (8) @(negedge sys_clk);
    chk_disp(4'hE, 8'h8A);
    blink_mask = 32'h0000_0000;
    $display("test blink done");
    scan_limit = 2'h1;
    put(2'h1, 8'h7F);
    seen = 4'hF;
    repeat (40) begin
      @(negedge sys_clk);
      chk_word({15'h0, digit_sink_lines == 4'hE || digit_sink_lines == 4'hD}, 16'h0001,
               "one digit");
      chk_word({8'h0, point_source_line, segment_source_lines},
               (digit_sink_lines == 4'hE) ? 16'h008A : 16'h007F, "digit segs");
      seen &= digit_sink_lines;
    end
    chk_word({12'h0, seen}, 16'h000C, "rotation");
    // external scan clock: slot holds until its rising edge
    ext_clk_sel = 1'b1;
    repeat (2) @(negedge sys_clk);
    seen = digit_sink_lines;
    repeat (20) @(negedge sys_clk);
    chk_word({12'h0, digit_sink_lines}, {12'h0, seen}, "held slot");
    ext_scan_clk = 1'b1;
    @(negedge sys_clk);
    ext_scan_clk = 1'b0;
    repeat (2) @(negedge sys_clk);
    chk_word({12'h0, digit_sink_lines}, {12'h0, seen ^ 4'h3}, "ext step");
    ext_clk_sel = 1'b0;
    sw_reset = 1'b1;
    @(negedge sys_clk);
    sw_reset = 1'b0;
    repeat (3) @(negedge sys_clk);
    chk_disp(4'hF, 8'h00);
    chk_word({15'h0, cmd_overflow}, 16'h0000, "overflow cleared");
    $display("test scan done");
    complete_run();
  end
endmodule
`default_nettype wire
